/* File: lcdl_pkg.sv */
// lcdl_pkg: constants, types and settings records shared by the display loader blocks
package lcdl_pkg;

  // seven-bit slave address, top six bits fixed, lsb from the strap
  localparam logic [5:0] SLAVE_ADDR_HI  = 6'h1F;
  localparam int         RAM_DEPTH      = 24;
  localparam logic [4:0] PTR_LAST       = 5'h17;
  localparam logic [4:0] PTR_RESET      = 5'h00;
  localparam logic [2:0] SUBADDR_RESET  = 3'h0;

  // command opcode fields, matched on bits 6..0 of a command byte
  localparam int         CMD_CONT_BIT   = 7;
  localparam logic [1:0] OPC_MODE_SET   = 2'h2;
  localparam logic [1:0] OPC_LOAD_PTR   = 2'h0;
  localparam logic [3:0] OPC_DEV_SEL    = 4'hC;
  localparam logic [4:0] OPC_BANK_SEL   = 5'h1E;
  localparam logic [3:0] OPC_BLINK      = 4'hE;

  // drive mode codes as carried in the mode set command
  localparam logic [1:0] MODE_STATIC    = 2'h1;
  localparam logic [1:0] MODE_MUX2      = 2'h2;
  localparam logic [1:0] MODE_MUX3      = 2'h3;
  localparam logic [1:0] MODE_MUX4      = 2'h0;

  // blink frequency codes
  localparam logic [1:0] BLINK_OFF      = 2'h0;
  localparam logic [1:0] BLINK_2HZ      = 2'h1;
  localparam logic [1:0] BLINK_1HZ      = 2'h2;
  localparam logic [1:0] BLINK_HALF_HZ  = 2'h3;

  // clock-to-blink ratios, normal and power-saving
  localparam int RATIO_N_2HZ  = 92160;
  localparam int RATIO_N_1HZ  = 184320;
  localparam int RATIO_N_05HZ = 368640;
  localparam int RATIO_P_2HZ  = 15360;
  localparam int RATIO_P_1HZ  = 30720;
  localparam int RATIO_P_05HZ = 61440;

  // clock cycles per stored display bit; power-saving is six times slower
  localparam logic [2:0] STORE_STEP_NORMAL = 3'h1;
  localparam logic [2:0] STORE_STEP_SAVE   = 3'h6;

  localparam logic [4:0] MODE_SET_RESET  = 5'h00;
  localparam logic [2:0] BLINK_SET_RESET = 3'h0;
  localparam logic [1:0] BANK_SET_RESET  = 2'h0;

  typedef struct packed {
    logic       power_save;
    logic       display_en;
    logic       bias_half;
    logic [1:0] drive_mode;
  } lcdl_mode_t;

  typedef struct packed {
    logic       alternate;
    logic [1:0] freq;
  } lcdl_blink_t;

  typedef struct packed {
    logic in_alt;
    logic out_alt;
  } lcdl_bank_t;

  typedef logic [RAM_DEPTH-1:0][3:0] lcdl_ram_t;

endpackage

/* File: lcdl_blinker.sv */
// lcdl_blinker: blink phase divider from the system clock
`timescale 1ns/1ps
`default_nettype none
module lcdl_blinker
  import lcdl_pkg::*;
#(
  parameter int N_2HZ  = RATIO_N_2HZ,
  parameter int N_1HZ  = RATIO_N_1HZ,
  parameter int N_05HZ = RATIO_N_05HZ,
  parameter int P_2HZ  = RATIO_P_2HZ,
  parameter int P_1HZ  = RATIO_P_1HZ,
  parameter int P_05HZ = RATIO_P_05HZ
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire lcdl_blink_t blink,
  input  wire logic        power_save,
  output logic             off_phase
);

  logic [18:0] count;
  logic [18:0] half_ratio;
  logic        wrap;

  // phase toggles every half period, so a full period spans the ratio
  assign half_ratio = (blink.freq == BLINK_2HZ) ? 19'((power_save ? P_2HZ : N_2HZ) / 2) :
                      (blink.freq == BLINK_1HZ) ? 19'((power_save ? P_1HZ : N_1HZ) / 2) :
                      19'((power_save ? P_05HZ : N_05HZ) / 2);
  assign wrap = (count >= half_ratio - 19'h00001);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count     <= 19'h00000;
      off_phase <= 1'b0;
    end else if (blink.freq == BLINK_OFF) begin
      count     <= 19'h00000;
      off_phase <= 1'b0;
    end else if (wrap) begin
      count     <= 19'h00000;
      off_phase <= ~off_phase;
    end else begin
      count <= count + 19'h00001;
    end
  end

endmodule // lcdl_blinker
`default_nettype wire

/* File: lcdl_out_bank.sv */
// lcdl_out_bank: output bank selector feeding the display latch in multiplex order
`timescale 1ns/1ps
`default_nettype none
module lcdl_out_bank
  import lcdl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire lcdl_ram_t   ram,
  input  wire lcdl_mode_t  mode,
  input  wire lcdl_blink_t blink,
  input  wire logic        out_alt,
  input  wire logic        blink_off,
  input  wire logic        mux_step,
  output logic [23:0]      seg_data,
  output logic [1:0]       bp_phase
);

  logic [1:0] last_phase;
  logic       has_alt;
  logic       use_alt;
  logic [1:0] bit_sel;
  logic       blank;
  logic [1:0] next_phase;

  assign last_phase = (mode.drive_mode == MODE_STATIC) ? 2'h0 :
                      (mode.drive_mode == MODE_MUX2)   ? 2'h1 :
                      (mode.drive_mode == MODE_MUX3)   ? 2'h2 : 2'h3;
  assign has_alt = (mode.drive_mode == MODE_STATIC) || (mode.drive_mode == MODE_MUX2);
  // in static and two-backplane modes alternation swaps banks at the blink rate rather than blanking
  assign use_alt = has_alt && (out_alt ^ (blink.alternate && blink_off));
  assign bit_sel = use_alt ? (next_phase + 2'h2) : next_phase;
  assign blank   = !mode.display_en || (!blink.alternate && blink_off);
  assign next_phase = (!mux_step) ? ((bp_phase > last_phase) ? 2'h0 : bp_phase) :
                      (bp_phase >= last_phase) ? 2'h0 : bp_phase + 2'h1;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bp_phase <= 2'h0;
    end else begin
      bp_phase <= next_phase;
    end
  end

  genvar s;
  generate
    for (s = 0; s < RAM_DEPTH; s++) begin : g_seg
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          seg_data[s] <= 1'b0;
        end else begin
          seg_data[s] <= blank ? 1'b0 : ram[s][bit_sel];
        end
      end
    end
  endgenerate

endmodule // lcdl_out_bank
`default_nettype wire

/* File: lcdl_loader.sv */
// lcdl_loader: receive-only two-wire slave, command decoder, display RAM and cascade subaddressing
`timescale 1ns/1ps
`default_nettype none
module lcdl_loader
  import lcdl_pkg::*;
#(
  parameter int N_2HZ  = RATIO_N_2HZ,
  parameter int N_1HZ  = RATIO_N_1HZ,
  parameter int N_05HZ = RATIO_N_05HZ,
  parameter int P_2HZ  = RATIO_P_2HZ,
  parameter int P_1HZ  = RATIO_P_1HZ,
  parameter int P_05HZ = RATIO_P_05HZ
) (
  input  wire logic  clk,
  input  wire logic  rstn,
  input  wire logic  scl_in,
  output logic       scl_out,
  output logic       scl_oe,
  input  wire logic  sda_in,
  output logic       sda_out,
  output logic       sda_oe,
  input  wire logic  hw_subaddr_bit_lo,
  input  wire logic  hw_subaddr_bit_mid,
  input  wire logic  hw_subaddr_bit_hi,
  input  wire logic  slave_addr_lsb_strap,
  input  wire logic  mux_step,
  output logic [23:0] seg_data,
  output logic [1:0] bp_phase,
  output lcdl_mode_t mode,
  output logic       blink_off
);

  typedef enum logic [2:0] {LCDL_IDLE, LCDL_ADDR, LCDL_CMD, LCDL_DATA, LCDL_SKIP} lcdl_state_t;

  lcdl_state_t state;
  logic        scl_q;
  logic        sda_q;
  logic [3:0]  bit_cnt;
  logic [7:0]  shreg;
  logic        ack_phase;
  logic        byte_pulse;
  logic [7:0]  byte_val;
  logic        byte_is_cmd;

  lcdl_blink_t blink;
  lcdl_bank_t  bank;
  lcdl_ram_t   ram;
  logic [4:0]  ptr;
  logic [2:0]  subaddr;
  logic        busy;
  logic [7:0]  st_data;
  logic [3:0]  st_left;
  logic [1:0]  st_pos;
  logic [2:0]  st_wait;
  logic        stretch;

  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic [2:0]  hw_subaddr;
  logic        sub_match;
  logic        addr_match;
  logic        ack_now;
  logic [1:0]  last_pos;
  logic [1:0]  bank_base;
  logic [1:0]  wr_bit;
  logic        step_now;
  logic        end_of_addr;
  logic        ptr_wrap;
  logic [4:0]  next_ptr;
  logic [2:0]  next_subaddr;
  logic        cmd_pulse;
  logic        data_pulse;
  logic        is_mode_set;
  logic        is_load_ptr;
  logic        is_dev_sel;
  logic        is_bank_sel;
  logic        is_blink;
  logic [2:0]  store_step;
  logic        ram_we;

  assign scl_rise   = scl_in & ~scl_q;
  assign scl_fall   = ~scl_in & scl_q;
  assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_cond  = scl_in & scl_q & ~sda_q & sda_in;
  assign hw_subaddr = {hw_subaddr_bit_hi, hw_subaddr_bit_mid, hw_subaddr_bit_lo};
  assign sub_match  = (subaddr == hw_subaddr);
  // judged at the fall after bit 8, when shreg holds the seven address bits and the write bit
  assign addr_match = (shreg[7:1] == {SLAVE_ADDR_HI, slave_addr_lsb_strap}) && !shreg[0];
  assign ack_now    = (state == LCDL_ADDR) ? addr_match :
                      (state == LCDL_CMD)  ? 1'b1 :
                      (state == LCDL_DATA) ? sub_match : 1'b0;

  // the device only ever pulls the lines low, so no pull-up level is ever driven
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign scl_oe  = stretch;

  // two-wire receiver; the device only ever pulls SDA low for acknowledge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_q       <= 1'b1;
      sda_q       <= 1'b1;
      state       <= LCDL_IDLE;
      bit_cnt     <= 4'h0;
      shreg       <= 8'h00;
      ack_phase   <= 1'b0;
      sda_oe      <= 1'b0;
      byte_pulse  <= 1'b0;
      byte_val    <= 8'h00;
      byte_is_cmd <= 1'b0;
    end else begin
      scl_q      <= scl_in;
      sda_q      <= sda_in;
      byte_pulse <= 1'b0;
      if (start_cond) begin
        state     <= LCDL_ADDR;
        bit_cnt   <= 4'h0;
        ack_phase <= 1'b0;
        sda_oe    <= 1'b0;
      end else if (stop_cond) begin
        state     <= LCDL_IDLE;
        ack_phase <= 1'b0;
        sda_oe    <= 1'b0;
      end else if (state != LCDL_IDLE && state != LCDL_SKIP) begin
        if (scl_rise && bit_cnt < 4'h8) begin
          shreg   <= {shreg[6:0], sda_in};
          bit_cnt <= bit_cnt + 4'h1;
        end else if (scl_fall && bit_cnt == 4'h8 && !ack_phase) begin
          ack_phase <= 1'b1;
          sda_oe    <= ack_now;
          if (state != LCDL_ADDR) begin
            byte_pulse  <= 1'b1;
            byte_val    <= shreg;
            byte_is_cmd <= (state == LCDL_CMD);
          end
        end else if (scl_fall && ack_phase) begin
          // release only after the ninth clock has fallen
          ack_phase <= 1'b0;
          sda_oe    <= 1'b0;
          bit_cnt   <= 4'h0;
          if (state == LCDL_ADDR) begin
            state <= addr_match ? LCDL_CMD : LCDL_SKIP;
          end else if (state == LCDL_CMD && !byte_val[CMD_CONT_BIT]) begin
            state <= LCDL_DATA;
          end
        end
      end
    end
  end

  // store engine: one display bit per step so a pointer overflow can fall mid-byte
  assign last_pos  = (mode.drive_mode == MODE_STATIC) ? 2'h0 :
                     (mode.drive_mode == MODE_MUX2)   ? 2'h1 :
                     (mode.drive_mode == MODE_MUX3)   ? 2'h2 : 2'h3;
  assign bank_base = (bank.in_alt && (mode.drive_mode == MODE_STATIC || mode.drive_mode == MODE_MUX2))
                     ? 2'h2 : 2'h0;
  assign wr_bit    = st_pos + bank_base;
  assign step_now  = busy && (st_wait == 3'h1);
  // a partly filled address (three backplanes) still moves the pointer on
  assign end_of_addr = (st_pos == last_pos) || (st_left == 4'h1 && st_pos != 2'h0);
  assign ptr_wrap  = (ptr >= PTR_LAST);
  assign next_ptr  = ptr_wrap ? PTR_RESET : ptr + 5'h01;
  assign next_subaddr = ptr_wrap ? subaddr + 3'h1 : subaddr;
  assign ram_we    = step_now && sub_match;

  // opcodes are matched on bits 6..0; the continuation bit plays no part here
  assign cmd_pulse   = byte_pulse && byte_is_cmd;
  assign data_pulse  = byte_pulse && !byte_is_cmd;
  assign is_mode_set = (byte_val[6:5] == OPC_MODE_SET);
  assign is_load_ptr = (byte_val[6:5] == OPC_LOAD_PTR);
  assign is_dev_sel  = (byte_val[6:3] == OPC_DEV_SEL);
  assign is_bank_sel = (byte_val[6:2] == OPC_BANK_SEL);
  assign is_blink    = (byte_val[6:3] == OPC_BLINK);
  // power-saving runs the store six times slower, which is what makes stretching necessary
  assign store_step  = mode.power_save ? STORE_STEP_SAVE : STORE_STEP_NORMAL;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode    <= MODE_SET_RESET;
      blink   <= BLINK_SET_RESET;
      bank    <= BANK_SET_RESET;
      ptr     <= PTR_RESET;
      subaddr <= SUBADDR_RESET;
      busy    <= 1'b0;
      st_data <= 8'h00;
      st_left <= 4'h0;
      st_pos  <= 2'h0;
      st_wait <= 3'h0;
      ram     <= '0;
    end else if (cmd_pulse) begin
      if (is_mode_set) begin
        mode <= byte_val[4:0];
      end else if (is_load_ptr) begin
        ptr <= byte_val[4:0];
      end else if (is_dev_sel) begin
        subaddr <= byte_val[2:0];
      end else if (is_bank_sel) begin
        bank <= byte_val[1:0];
      end else if (is_blink) begin
        blink <= byte_val[2:0];
      end
    end else if (data_pulse) begin
      busy    <= 1'b1;
      st_data <= byte_val;
      st_left <= 4'h8;
      st_pos  <= 2'h0;
      st_wait <= store_step;
    end else if (step_now) begin
      // msb of the byte lands first, at the lowest bit of the bank
      if (ram_we) begin
        ram[ptr][wr_bit] <= st_data[7];
      end
      st_data <= {st_data[6:0], 1'b0};
      st_left <= st_left - 4'h1;
      st_wait <= store_step;
      if (end_of_addr) begin
        ptr     <= next_ptr;
        subaddr <= next_subaddr;
        st_pos  <= 2'h0;
      end else begin
        st_pos <= st_pos + 2'h1;
      end
      if (st_left == 4'h1) begin
        busy <= 1'b0;
      end
    end else if (busy) begin
      st_wait <= st_wait - 3'h1;
    end
  end

  // stretch from the end of the acknowledge clock until the store finishes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stretch <= 1'b0;
    end else if (!busy || stop_cond || start_cond) begin
      stretch <= 1'b0;
    end else if (scl_fall && ack_phase) begin
      stretch <= 1'b1;
    end
  end

  lcdl_blinker #(
    .N_2HZ  (N_2HZ),
    .N_1HZ  (N_1HZ),
    .N_05HZ (N_05HZ),
    .P_2HZ  (P_2HZ),
    .P_1HZ  (P_1HZ),
    .P_05HZ (P_05HZ)
  ) u_blinker (
    .clk        (clk),
    .rstn       (rstn),
    .blink      (blink),
    .power_save (mode.power_save),
    .off_phase  (blink_off)
  );

  lcdl_out_bank u_out_bank (
    .clk       (clk),
    .rstn      (rstn),
    .ram       (ram),
    .mode      (mode),
    .blink     (blink),
    .out_alt   (bank.out_alt),
    .blink_off (blink_off),
    .mux_step  (mux_step),
    .seg_data  (seg_data),
    .bp_phase  (bp_phase)
  );

endmodule // lcdl_loader
`default_nettype wire

/* File: lcdl_loader_props.sv */
// lcdl_loader_props: port-level assertions for the display loader
`timescale 1ns/1ps
`default_nettype none
module lcdl_loader_props
  import lcdl_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        mux_step,
  input wire logic [1:0]  bp_phase,
  input wire lcdl_mode_t  mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_OPEN_DRAIN: assert property (!scl_out && !sda_out)
    else $error("open-drain line driven high");
  AST_ACK_START: assert property ($rose(sda_oe) |-> !$past(scl_in) && $past(scl_in, 2))
    else $error("acknowledge began away from a clock fall");
  AST_ACK_END: assert property ($fell(sda_oe) |-> !scl_in && !$past(scl_in) && $past(scl_in, 2))
    else $error("acknowledge released outside the ninth fall");
  AST_ACK_BOUND: assert property ($rose(sda_oe) |-> ##[1:400] !sda_oe)
    else $error("data line held too long");
  AST_STRETCH_START: assert property ($rose(scl_oe) |-> !scl_in && !$past(scl_in) && $past(scl_in, 2))
    else $error("clock stretch not tied to acknowledge end");
  AST_STRETCH_BOUND: assert property ($rose(scl_oe) |-> ##[1:60] !scl_oe)
    else $error("clock stretch outlasts a byte store");
  AST_STATIC_PHASE: assert property (mux_step && mode.drive_mode == MODE_STATIC |=> bp_phase == 2'h0)
    else $error("static mode left phase zero");
  AST_MUX2_PHASE: assert property (mux_step && mode.drive_mode == MODE_MUX2 |=> bp_phase == {1'b0, ~$past(bp_phase[0])})
    else $error("duplex phase order wrong");
  AST_MUX4_PHASE: assert property (mux_step && mode.drive_mode == MODE_MUX4 |=> bp_phase == $past(bp_phase) + 2'h1)
    else $error("four backplane phase order wrong");
endmodule // lcdl_loader_props
`default_nettype wire

/* File: lcdl_i2c_master.sv */
// lcdl_i2c_master: behavioural two-wire bus master
`timescale 1ns/1ps
`default_nettype none
module lcdl_i2c_master (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output var logic  scl_low,
  output var logic  sda_low
);
  localparam int HALF = 6;

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  task automatic gap();
    repeat (HALF) @(negedge clk);
  endtask

  // release the clock and wait out any stretch by a slave
  task automatic rise();
    scl_low = 1'b0;
    for (int i = 0; i < 300 && scl !== 1'b1; i++) @(negedge clk);
    gap();
  endtask

  task automatic start_c();
    sda_low = 1'b0;
    rise();
    sda_low = 1'b1;
    gap();
    scl_low = 1'b1;
  endtask

  // data changes only well inside the low phase
  task automatic bit_c(input logic b, output logic s);
    repeat (2) @(negedge clk);
    sda_low = ~b;
    gap();
    rise();
    s = sda;
    scl_low = 1'b1;
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(d[i], s);
    bit_c(1'b1, s);
    ack = ~s;
  endtask

  task automatic stop_c();
    repeat (2) @(negedge clk);
    sda_low = 1'b1;
    gap();
    rise();
    sda_low = 1'b0;
    gap();
  endtask
endmodule // lcdl_i2c_master
`default_nettype wire

/* File: lcdl_loader_tb_top.sv */
// lcdl_loader_tb_top: self-checking bench for the display loader
`timescale 1ns/1ps
`default_nettype none
module lcdl_loader_tb_top;
  import lcdl_pkg::*;
  logic        clk, rstn, mux_step, sa0, m_scl, m_sda;
  logic [2:0]  sub;
  wire         scl_w, sda_w;
  logic        scl_out, scl_oe, sda_out, sda_oe, blink_off;
  logic [23:0] seg_data;
  logic [1:0]  bp_phase;
  lcdl_mode_t  mode;
  int          n_fail, cmp_count, g;

  // open-drain wires with pull-ups
  assign scl_w = ~(m_scl | (scl_oe & ~scl_out));
  assign sda_w = ~(m_sda | (sda_oe & ~sda_out));

  lcdl_loader #(.N_2HZ(40), .N_1HZ(80), .N_05HZ(160), .P_2HZ(20), .P_1HZ(40), .P_05HZ(80)) DUT (
    .clk(clk), .rstn(rstn), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .hw_subaddr_bit_lo(sub[0]),
    .hw_subaddr_bit_mid(sub[1]), .hw_subaddr_bit_hi(sub[2]), .slave_addr_lsb_strap(sa0),
    .mux_step(mux_step), .seg_data(seg_data), .bp_phase(bp_phase), .mode(mode), .blink_off(blink_off));

  lcdl_i2c_master m (.clk(clk), .scl(scl_w), .sda(sda_w), .scl_low(m_scl), .sda_low(m_sda));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk_val(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_ack(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  // one transfer: first byte is the address, acks holds the expected answer per byte
  task automatic xfer(input logic [7:0] q[$], input logic [15:0] acks);
    logic a;
    m.start_c();
    foreach (q[i]) begin
      m.wr_byte(q[i], a);
      chk_ack($sformatf("ack of byte %0d", i), acks[i], a);
    end
    m.stop_c();
  endtask

  task automatic step(input int n);
    repeat (n) begin
      @(negedge clk);
      mux_step = 1'b1;
      @(negedge clk);
      mux_step = 1'b0;
    end
    repeat (2) @(negedge clk);
  endtask

  task automatic wait_blink(input logic lvl);
    for (int i = 0; i < 400 && blink_off !== lvl; i++) @(negedge clk);
    repeat (2) @(negedge clk);
  endtask

  // half blink period in clocks, measured from a full phase
  task automatic meas();
    wait_blink(1'b1);
    wait_blink(1'b0);
    g = 2;
    while (blink_off !== 1'b1 && g < 400) begin
      @(negedge clk);
      g++;
    end
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    $display("Error watchdog expected finish seen timeout");
    summarize();
  end

  initial begin
    rstn = 1'b0;
    mux_step = 1'b0;
    sa0 = 1'b0;
    sub = 3'h5;
    n_fail = 0;
    cmp_count = 0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    xfer('{8'h7E, 8'h49}, 16'h0);
    xfer('{8'h7D}, 16'h0);
    chk_val("mode after ignored", 24'h0, 24'(mode));
    $display("test address done");
    sa0 = 1'b1;
    xfer('{8'h7E, 8'hC9, 8'hE5, 8'h80, 8'h78, 8'hA5}, 16'h3F);
    chk_val("mode", 24'h9, 24'(mode));
    xfer('{8'h7E, 8'hE4, 8'h78, 8'hFF}, 16'h7);
    xfer('{8'h7E, 8'hE5, 8'h78, 8'h3C, 8'hFF}, 16'hF);
    chk_val("static column", 24'h3C00A5, seg_data);
    step(1);
    chk_val("static after step", 24'h3C00A5, seg_data);
    $display("test cascade done");
    xfer('{8'h7E, 8'hCA, 8'hE5, 8'h96, 8'h78, 8'hF0}, 16'h3F);
    chk_val("duplex col0", 24'hFC00A5, seg_data);
    step(1);
    chk_val("duplex col1", 24'hC00000, seg_data);
    step(1);
    xfer('{8'h7E, 8'hE5, 8'h80, 8'h7A, 8'hFF}, 16'h1F);
    chk_val("display bank kept", 24'hFC00A5, seg_data);
    xfer('{8'h7E, 8'h7B}, 16'h3);
    chk_val("alt col0", 24'h00000F, seg_data);
    step(1);
    chk_val("alt col1", 24'h00000F, seg_data);
    step(1);
    $display("test banks done");
    xfer('{8'h7E, 8'h75}, 16'h3);
    wait_blink(1'b1);
    chk_val("swap off phase", 24'hFC00A5, seg_data);
    wait_blink(1'b0);
    chk_val("swap on phase", 24'h00000F, seg_data);
    for (int ps = 0; ps < 2; ps++)
      for (int f = 1; f < 4; f++) begin
        xfer('{8'h7E, 8'hCA | 8'(ps * 16), 8'h74 | 8'(f)}, 16'h7);
        meas();
        chk_val("blink half period", 24'((ps == 1 ? 10 : 20) << (f - 1)), 24'(g));
      end
    xfer('{8'h7E, 8'hCA, 8'h71}, 16'h7);
    wait_blink(1'b1);
    chk_val("blink blank", 24'h0, seg_data);
    wait_blink(1'b0);
    chk_val("blink shown", 24'h00000F, seg_data);
    $display("test blink done");
    xfer('{8'h7E, 8'hD8, 8'hE5, 8'h84, 8'h70, 8'h96, 8'h00}, 16'h7F);
    for (int p = 0; p < 4; p++) begin
      chk_val("4bp column", 24'((p == 1 || p == 2) ? 2 : 1), 24'(seg_data[7:4]));
      chk_val("4bp phase", 24'(p), 24'(bp_phase));
      step(1);
    end
    for (int i = 0; i < 8; i++)
      xfer('{8'h7E, 8'h60 | 8'(i), 8'h00}, 16'h3 | (i == 5 ? 16'h4 : 16'h0));
    $display("test power save and select done");
    sub = 3'h2;
    xfer('{8'h7E, 8'hCB, 8'hE2, 8'h88, 8'h70, 8'hB6, 8'hE0}, 16'h7F);
    for (int p = 0; p < 4; p++) begin
      chk_val("3bp column", 24'(p == 1 ? 8'h08 : p == 2 ? 8'h0B : 8'h0F), 24'(seg_data[15:8]));
      chk_val("3bp phase", 24'(p % 3), 24'(bp_phase));
      step(1);
    end
    xfer('{8'h7E, 8'h43}, 16'h3);
    chk_val("host blink off", 24'h0, seg_data);
    xfer('{8'h7E, 8'h4B}, 16'h3);
    chk_val("host blink on", 24'h08, 24'(seg_data[15:8]));
    $display("test three backplane and host blink done");
    summarize();
  end
endmodule // lcdl_loader_tb_top

bind lcdl_loader lcdl_loader_props u_props (
  .clk(clk), .rstn(rstn), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
  .sda_oe(sda_oe), .mux_step(mux_step), .bp_phase(bp_phase), .mode(mode));
`default_nettype wire
